/* File: pkg/sarseq_pkg.sv */
// Shared constants, types and register map of the SAR conversion sequencer
package sarseq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_CTRL_C = 8'h08;
	localparam logic [7:0] OFS_RES_HI = 8'h0c;
	localparam logic [7:0] OFS_RES_LO = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_PORT   = 8'h18;

	// Field positions
	localparam int CA_ENABLE  = 0;
	localparam int CA_GO      = 1;
	localparam int CA_CHAN_LO = 2;
	localparam int CB_PCFG_LO = 0;
	localparam int CB_VREF_LO = 4;
	localparam int CC_CSEL_LO = 0;
	localparam int CC_ACQ_LO  = 3;
	localparam int CC_RJUST   = 7;
	localparam int SR_FLAG    = 0;

	// Reset values of the port configuration field, chosen by the strap
	localparam logic [3:0] PCFG_RST_ANALOG  = 4'h0;
	localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS      = 40;
	localparam int OSC_PER_INSTR      = 4;
	localparam int INSTR_CYCLE_NS     = OSC_PER_INSTR * CLK_PERIOD_NS;
	localparam int INSTR_CYCLE_CLKS   = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	localparam int SETTLE_INSTR       = 2;
	localparam int SETTLE_CLKS        = SETTLE_INSTR * INSTR_CYCLE_CLKS;
	localparam int FRC_PERIOD_NS      = 1000;
	localparam int FRC_DIV            = FRC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [4:0] DELAY_LAST  = 5'(INSTR_CYCLE_CLKS - 1);
	localparam logic [4:0] SETTLE_LAST = 5'(SETTLE_CLKS - 1);

	// Converter geometry
	localparam int RES_BITS = 12;
	localparam int NUM_CHAN = 13;
	localparam logic [4:0] MSB_IDX      = 5'(RES_BITS - 1);
	localparam logic [11:0] SAR_FIRST   = 12'h800;
	localparam logic [4:0] PCFG_LIMIT   = 5'h0f;

	// Conversion clock selections running from the internal RC source
	localparam logic [2:0] CSEL_FRC_A = 3'h3;
	localparam logic [2:0] CSEL_FRC_B = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_OFF    = 7'h01,
		ST_SETTLE = 7'h02,
		ST_DISCH  = 7'h04,
		ST_TRACK  = 7'h08,
		ST_DELAY  = 7'h10,
		ST_ACQ    = 7'h20,
		ST_CONV   = 7'h40
	} sarseq_state_t;

	// APB request and answer
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sarseq_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} sarseq_apb_rsp_t;

	// Controls toward the analog front end
	typedef struct packed {
		logic        power;
		logic        discharge;
		logic        sample;
		logic [1:0]  vref_sel;
		logic [3:0]  channel_select;
		logic [11:0] dac;
	} sarseq_ana_t;

	// Acquisition code to conversion-clock periods
	function automatic logic [4:0] acq_tads(input logic [2:0] code);
		case (code)
			3'h0: acq_tads = 5'd0;
			3'h1: acq_tads = 5'd2;
			3'h2: acq_tads = 5'd4;
			3'h3: acq_tads = 5'd6;
			3'h4: acq_tads = 5'd8;
			3'h5: acq_tads = 5'd12;
			3'h6: acq_tads = 5'd16;
			default: acq_tads = 5'd20;
		endcase
	endfunction

	// Clock select code to divider ratio
	function automatic logic [7:0] csel_div(input logic [2:0] code);
		case (code)
			3'h0: csel_div = 8'd2;
			3'h1: csel_div = 8'd8;
			3'h2: csel_div = 8'd32;
			3'h4: csel_div = 8'd4;
			3'h5: csel_div = 8'd16;
			3'h6: csel_div = 8'd64;
			default: csel_div = 8'(FRC_DIV);
		endcase
	endfunction

endpackage

/* File: core/sarseq_tad_gen.sv */
// Conversion-clock period tick generator
`timescale 1ns/1ps
`default_nettype none

module sarseq_tad_gen
	import sarseq_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_in,
	input  wire logic       rst_n_in,
	// Control
	input  wire logic       run_in,
	input  wire logic [7:0] div_in,
	// Tick
	output var  logic       tick_out
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} sarseq_tad_t;

	sarseq_tad_t r;
	sarseq_tad_t next_r;

	////////////////////////////////////////////////////////////////////////////
	// Divider, held in zero while stopped
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (!run_in) begin
			next_r.cnt = 8'h00;
		end else if (r.cnt == 8'(div_in - 8'h01)) begin
			next_r.cnt  = 8'h00;
			next_r.tick = 1'b1;
		end else begin
			next_r.cnt = 8'(r.cnt + 8'h01);
		end
		if (!rst_n_in) begin
			next_r = '0;
		end
	end

	always_ff @(posedge mclk_in) begin
		r <= next_r;
	end

	assign tick_out = r.tick;

endmodule

`default_nettype wire

/* File: core/sarseq_core.sv */
// SAR converter sequencer with APB register file
`timescale 1ns/1ps
`default_nettype none

module sarseq_core
	import sarseq_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             rst_n_in,
	// Register bus
	input  wire sarseq_apb_req_t  apb_req_in,
	output var  sarseq_apb_rsp_t  apb_rsp_out,
	// Analog front end
	input  wire logic             comp_in,
	output var  sarseq_ana_t      ana_out,
	// Device status and straps
	input  wire logic             sleep_in,
	input  wire logic             port_b_analog_reset_cfg_in,
	input  wire logic [12:0]      port_pins_in,
	// Completion flag
	output var  logic             conv_complete_flag_out
);

	typedef struct packed {
		sarseq_state_t   st;
		logic            en;
		logic [3:0]      chan;
		logic [3:0]      pcfg;
		logic [1:0]      vref;
		logic            rjust;
		logic [2:0]      acq;
		logic [2:0]      csel;
		logic [7:0]      res_hi;
		logic [7:0]      res_lo;
		logic            flag;
		logic [4:0]      cnt;
		logic [11:0]     sar;
		sarseq_apb_rsp_t rsp;
		sarseq_ana_t     ana;
	} sarseq_core_t;

	sarseq_core_t r;
	sarseq_core_t next_r;
	logic         tad_tick;
	logic         tad_run;
	logic         is_frc;
	logic         busy;
	logic [12:0]  amask;
	logic         setup;
	logic         wr;
	logic         wr_a;
	logic         start_wr;
	logic         abort_wr;

	////////////////////////////////////////////////////////////////////////////
	// Decode of bus phases and control writes
	assign setup    = apb_req_in.psel && !apb_req_in.penable;
	assign wr       = apb_req_in.psel && apb_req_in.penable && r.rsp.pready
		&& apb_req_in.pwrite;
	assign wr_a     = wr && (apb_req_in.paddr == OFS_CTRL_A);
	assign is_frc   = (r.csel == CSEL_FRC_A) || (r.csel == CSEL_FRC_B);
	assign busy     = (r.st == ST_DELAY) || (r.st == ST_ACQ) || (r.st == ST_CONV);
	// Go only honoured once already enabled and tracking
	assign start_wr = wr_a && apb_req_in.pwdata[CA_GO] && apb_req_in.pwdata[CA_ENABLE]
		&& r.en && (r.st == ST_TRACK);
	assign abort_wr = wr_a && !apb_req_in.pwdata[CA_GO] && busy;

	// Period ticks stop in sleep unless the RC source drives them
	assign tad_run = ((r.st == ST_DISCH) || (r.st == ST_ACQ) || (r.st == ST_CONV))
		&& !(sleep_in && !is_frc);

	// Pins configured analog, count falls as the field rises
	always_comb begin
		amask = 13'h0000;
		for (int i = 0; i < NUM_CHAN; i++) begin
			amask[i] = (5'(i) + {1'b0, r.pcfg}) < PCFG_LIMIT;
		end
	end

	sarseq_tad_gen u_tad (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n_in),
		.run_in   (tad_run),
		.div_in   (csel_div(r.csel)),
		.tick_out (tad_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus, registers, sequencer
	always_comb begin
		logic [11:0] res;
		logic [31:0] rdata;
		logic        mapped;
		res    = {r.sar[11:1], comp_in};
		rdata  = 32'h0000_0000;
		mapped = 1'b1;
		next_r = r;

		// Read mux, answered one cycle after setup
		if (apb_req_in.paddr == OFS_CTRL_A) begin
			rdata[7:0] = {2'b00, r.chan, busy, r.en};
		end else if (apb_req_in.paddr == OFS_CTRL_B) begin
			rdata[7:0] = {2'b00, r.vref, r.pcfg};
		end else if (apb_req_in.paddr == OFS_CTRL_C) begin
			rdata[7:0] = {r.rjust, 1'b0, r.acq, r.csel};
		end else if (apb_req_in.paddr == OFS_RES_HI) begin
			rdata[7:0] = r.res_hi;
		end else if (apb_req_in.paddr == OFS_RES_LO) begin
			rdata[7:0] = r.res_lo;
		end else if (apb_req_in.paddr == OFS_STATUS) begin
			rdata[SR_FLAG] = r.flag;
		end else if (apb_req_in.paddr == OFS_PORT) begin
			rdata[12:0] = port_pins_in & ~amask;
		end else begin
			mapped = 1'b0;
		end
		next_r.rsp.pready  = setup;
		next_r.rsp.pslverr = setup && !mapped;
		next_r.rsp.prdata  = setup ? rdata : 32'h0000_0000;

		// Register writes at the access edge
		if (wr_a) begin
			next_r.en   = apb_req_in.pwdata[CA_ENABLE];
			next_r.chan = apb_req_in.pwdata[CA_CHAN_LO +: 4];
		end
		if (wr && apb_req_in.paddr == OFS_CTRL_B) begin
			next_r.pcfg = apb_req_in.pwdata[CB_PCFG_LO +: 4];
			next_r.vref = apb_req_in.pwdata[CB_VREF_LO +: 2];
		end
		if (wr && apb_req_in.paddr == OFS_CTRL_C) begin
			next_r.rjust = apb_req_in.pwdata[CC_RJUST];
			next_r.acq   = apb_req_in.pwdata[CC_ACQ_LO +: 3];
			next_r.csel  = apb_req_in.pwdata[CC_CSEL_LO +: 3];
		end
		if (wr && apb_req_in.paddr == OFS_RES_HI) begin
			next_r.res_hi = apb_req_in.pwdata[7:0];
		end
		if (wr && apb_req_in.paddr == OFS_RES_LO) begin
			next_r.res_lo = apb_req_in.pwdata[7:0];
		end
		// Write one clears the flag; a set below wins
		if (wr && apb_req_in.paddr == OFS_STATUS && apb_req_in.pwdata[SR_FLAG]) begin
			next_r.flag = 1'b0;
		end

		// Sequencer
		case (r.st)
			ST_OFF: begin
				if (next_r.en) begin
					next_r.st  = ST_SETTLE;
					next_r.cnt = 5'd0;
				end
			end
			ST_SETTLE: begin
				next_r.cnt = 5'(r.cnt + 5'd1);
				if (r.cnt == SETTLE_LAST) begin
					next_r.st  = ST_DISCH;
					next_r.cnt = 5'd0;
				end
			end
			ST_DISCH: begin
				if (tad_tick) begin
					next_r.st = ST_TRACK;
				end
			end
			ST_TRACK: begin
				if (start_wr) begin
					if (r.acq == 3'h0 || is_frc) begin
						next_r.st  = ST_DELAY;
						next_r.cnt = 5'd0;
					end else begin
						next_r.st  = ST_ACQ;
						next_r.cnt = acq_tads(r.acq);
					end
				end
			end
			ST_DELAY: begin
				next_r.cnt = 5'(r.cnt + 5'd1);
				if (r.cnt == DELAY_LAST) begin
					if (r.acq == 3'h0) begin
						next_r.st  = ST_CONV;
						next_r.cnt = MSB_IDX;
						next_r.sar = SAR_FIRST;
					end else begin
						next_r.st  = ST_ACQ;
						next_r.cnt = acq_tads(r.acq);
					end
				end
			end
			ST_ACQ: begin
				if (tad_tick) begin
					next_r.cnt = 5'(r.cnt - 5'd1);
					if (r.cnt == 5'd1) begin
						next_r.st  = ST_CONV;
						next_r.cnt = MSB_IDX;
						next_r.sar = SAR_FIRST;
					end
				end
			end
			ST_CONV: begin
				// Keep trial bit if input is above the trial level
				if (tad_tick) begin
					next_r.sar[r.cnt[3:0]] = comp_in;
					if (r.cnt == 5'd0) begin
						if (r.rjust) begin
							next_r.res_hi = {4'h0, res[11:8]};
							next_r.res_lo = res[7:0];
						end else begin
							next_r.res_hi = res[11:4];
							next_r.res_lo = {res[3:0], 4'h0};
						end
						next_r.flag = 1'b1;
						next_r.st   = ST_SETTLE;
						next_r.cnt  = 5'd0;
					end else begin
						next_r.sar[4'(r.cnt - 5'd1)] = 1'b1;
						next_r.cnt = 5'(r.cnt - 5'd1);
					end
				end
			end
			default: begin
				next_r.st = ST_OFF;
			end
		endcase

		// Abort beats a coincident completion: results and flag kept
		if (abort_wr) begin
			next_r.st     = ST_SETTLE;
			next_r.cnt    = 5'd0;
			next_r.res_hi = r.res_hi;
			next_r.res_lo = r.res_lo;
			next_r.flag   = r.flag;
		end
		if (!next_r.en) begin
			next_r.st = ST_OFF;
		end

		// Front-end controls, registered; channel code passed through unchecked
		next_r.ana.power          = next_r.en;
		next_r.ana.discharge      = (next_r.st == ST_DISCH);
		next_r.ana.sample         = (next_r.st == ST_TRACK) || (next_r.st == ST_DELAY)
			|| (next_r.st == ST_ACQ);
		next_r.ana.vref_sel       = next_r.vref;
		next_r.ana.channel_select = next_r.chan;
		next_r.ana.dac            = next_r.sar;

		// Synchronous reset; strap picks the port configuration
		if (!rst_n_in) begin
			next_r      = '0;
			next_r.st   = ST_OFF;
			next_r.pcfg = port_b_analog_reset_cfg_in ? PCFG_RST_ANALOG
				: PCFG_RST_DIGITAL;
		end
	end

	always_ff @(posedge mclk_in) begin
		r <= next_r;
	end

	assign apb_rsp_out            = r.rsp;
	assign ana_out                = r.ana;
	assign conv_complete_flag_out = r.flag;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_reset_turns_off: assert property (@(posedge mclk_in) disable iff (1'b0)
		!rst_n_in |=> (r.st == ST_OFF) && !r.en && !r.flag)
		else $error("reset did not turn converter off");

	a_done_loads_flag: assert property (
		(r.st == ST_CONV && tad_tick && r.cnt == 5'd0 && !wr_a)
		|=> r.flag && (r.st == ST_SETTLE) && ($past(comp_in) ? (r.rjust
		? r.res_lo[0] : r.res_lo[4]) : 1'b1))
		else $error("completion did not load result and flag");

	a_abort_goes_wait: assert property (
		abort_wr && apb_req_in.pwdata[CA_ENABLE] |=> (r.st == ST_SETTLE) && !r.flag == !$past(r.flag))
		else $error("abort did not stop conversion");

	a_abort_keeps_res: assert property (
		abort_wr |=> (r.res_hi == $past(r.res_hi)) && (r.res_lo == $past(r.res_lo)))
		else $error("abort changed result registers");

	a_settle_wait: assert property (
		$rose(r.st == ST_SETTLE) |-> (r.st != ST_DISCH)[*8]
		##1 ((r.st == ST_DISCH) || !r.en))
		else $error("post-conversion wait length wrong");

	a_disch_before_track: assert property (
		$rose(r.st == ST_TRACK) |-> $past(r.st) == ST_DISCH)
		else $error("tracking started without discharge");

	a_acq_zero_delay: assert property (
		(start_wr && r.acq == 3'h0) |=> (r.st == ST_DELAY)[*4] ##1 (r.st != ST_DELAY))
		else $error("zero acquisition delay wrong");

	a_frc_delay: assert property (
		(start_wr && is_frc) |=> r.st == ST_DELAY)
		else $error("RC clock start lacks delay");

	a_acq_four: assert property (
		($rose(r.st == ST_ACQ) && r.acq == 3'h2) |-> r.cnt == 5'd4)
		else $error("acquisition length not four periods");

	a_sleep_stall: assert property (
		(r.st == ST_CONV && sleep_in && !is_frc && !tad_tick) |=> $stable(r.sar) && !tad_tick)
		else $error("conversion ran in sleep without RC clock");

	a_port_analog_zero: assert property (
		(setup && apb_req_in.paddr == OFS_PORT) |=> (r.rsp.prdata[12:0] & $past(amask)) == 13'h0)
		else $error("analog pin read as nonzero");

	a_twelve_bits: assert property (
		$rose(r.st == ST_CONV) |-> (r.cnt == MSB_IDX) && (r.sar == SAR_FIRST))
		else $error("conversion did not start at top bit");

	c_conv_done: cover property ($rose(r.flag));
	c_abort: cover property (abort_wr && r.st == ST_CONV);
	c_acq_four: cover property ($rose(r.st == ST_ACQ) && r.acq == 3'h2);
	c_sleep_frc: cover property (r.st == ST_CONV && sleep_in && is_frc && tad_tick);

endmodule

`default_nettype wire

/* File: verif/sarseq_ana_model.sv */
// Analog front end model: hold capacitor and comparator
`timescale 1ns/1ps
`default_nettype none

module sarseq_ana_model
	import sarseq_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// Controls and channel levels
	input  wire sarseq_ana_t       ana_in,
	input  wire logic [15:0][11:0] level_in,
	// Comparator
	output var  logic              comp_out
);
	logic [11:0] held;
	logic        junk = 1'b0;

	////////////////////////////////
	// Hold cap: emptied on discharge, follows selected level while sampling
	always @(posedge mclk_in) begin
		junk <= ~junk;
		if (!rst_n_in || ana_in.discharge) begin
			held <= 12'h000;
		end else if (ana_in.sample) begin
			held <= level_in[ana_in.channel_select];
		end
	end

	// Half-step offset so an equal trial always counts as above
	always_comb begin
		if (ana_in.power) begin
			comp_out = ({held, 1'b1} > {ana_in.dac, 1'b0});
		end else begin
			comp_out = junk; // Unpowered: meaningless answer
		end
	end
endmodule

`default_nettype wire

/* File: verif/sar_adc_conversion_sequencer_test.sv */
// Self-checking bench of the SAR conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_sequencer_test
	import sarseq_pkg::*;
;
	logic              mclk;
	logic              rst_n;
	sarseq_apb_req_t   req;
	sarseq_apb_rsp_t   rsp;
	sarseq_ana_t       ana;
	logic              comp;
	logic              sleep;
	logic              strap;
	logic [12:0]       pins;
	logic              flag;
	logic [15:0][11:0] lvl;
	logic [15:0]       seed;
	logic              samp_q, dis_q, flag_q, dis_seen;
	int                err_count, n_checks, cyc, t_done, t_dis;

	sarseq_core i_sarseq_core (
		.mclk_in(mclk), .rst_n_in(rst_n), .apb_req_in(req), .apb_rsp_out(rsp),
		.comp_in(comp), .ana_out(ana), .sleep_in(sleep),
		.port_b_analog_reset_cfg_in(strap), .port_pins_in(pins),
		.conv_complete_flag_out(flag)
	);

	sarseq_ana_model i_sarseq_ana_model (
		.mclk_in(mclk), .rst_n_in(rst_n), .ana_in(ana), .level_in(lvl), .comp_out(comp)
	);

	////////////////////////////////
	// Clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Event times and discharge-before-sample watch
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		samp_q <= ana.sample;
		dis_q <= ana.discharge;
		flag_q <= flag;
		if (ana.discharge) dis_seen <= 1'b1;
		if (ana.sample && !samp_q) begin
			check(32'(dis_seen), 32'h1);
			dis_seen <= 1'b0;
		end
		if (flag && !flag_q) t_done <= cyc;
		if (ana.discharge && !dis_q) t_dis <= cyc;
	end

	////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic int tad_div(input logic [2:0] c);
		int t[8] = '{2, 8, 32, FRC_DIV, 4, 16, 64, FRC_DIV};
		return t[c];
	endfunction

	function automatic int acq_len(input logic [2:0] a);
		int t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
		return t[a];
	endfunction

	function automatic logic [31:0] inr(input int v, input int a, input int b);
		return 32'(v >= a && v <= b);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One APB transfer, entered and left just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		n = 0;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 100);
		if (rsp.pready !== 1'b1) err_count++;
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask

	// Full conversion from tracking, results (channels below 13 only) and timing compared
	task automatic convert(input logic [2:0] cs, input logic [2:0] aq, input logic rj,
			input logic [3:0] ch);
		logic [31:0] q;
		logic [11:0] r;
		int          n, t0, lo;
		lo = (acq_len(aq) + 12) * tad_div(cs);
		seed = lfsr(seed);
		r = seed[11:0];
		lvl[ch] <= r;
		wr(OFS_CTRL_C, {rj, 1'b0, aq, cs});
		wr(OFS_CTRL_A, {2'b00, ch, 2'b01});
		check(32'(ana.channel_select), 32'(ch));
		wr(OFS_CTRL_A, {2'b00, ch, 2'b11});
		t0 = cyc;
		n = 0;
		while (flag !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		check(inr(cyc - t0, lo - 2, lo + tad_div(cs) + 10), 32'h1);
		rd(OFS_CTRL_A, q);
		check(32'(q[1]), 32'h0);
		if (ch < 4'd13) begin
			rd(OFS_RES_HI, q);
			check(q, rj ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
			rd(OFS_RES_LO, q);
			check(q, rj ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
		end
		rd(OFS_STATUS, q);
		check(q, 32'h1);
		wr(OFS_STATUS, 8'h01);
		check(32'(flag), 32'h0);
		wait_clk(SETTLE_CLKS + tad_div(cs) + 4);
		check(inr(t_dis - t_done, SETTLE_CLKS - 1, SETTLE_CLKS + 2), 32'h1);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (100000) @(posedge mclk);
		err_count++;
		$display("watchdog expired");
		complete_run;
	end

	////////////////////////////////
	// Main sequence
	initial begin
		logic [31:0] q, x;
		logic        e;
		int          t0;
		rst_n = 1'b0;
		req = '0;
		sleep = 1'b0;
		strap = 1'b1;
		pins = 13'h0;
		lvl = '0;
		seed = 16'd72;
		wait_clk(12);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), q);
			check(q, (i == 1) ? 32'(PCFG_RST_ANALOG) : 32'h0);
		end
		apb(1'b1, 8'h1c, 32'hff, q, e);
		apb(1'b0, 8'h1c, 32'h0, q, e);
		check({q[30:0], e}, 32'h1);
		$display("done: reset values");
		for (int p = 0; p < 16; p++) begin
			seed = lfsr(seed);
			pins <= seed[12:0];
			wr(OFS_CTRL_B, {2'b00, 2'(p), 4'(p)});
			x = {19'h0, seed[12:0]};
			for (int i = 0; i < 13; i++) if (i + p < 15) x[i] = 1'b0;
			rd(OFS_PORT, q);
			check(q, x);
			rd(OFS_CTRL_B, q);
			check(q, {26'h0, 2'(p), 4'(p)});
			check(32'(ana.vref_sel), 32'(p % 4));
		end
		$display("done: port and reference");
		wr(OFS_CTRL_A, 8'h01);
		check(32'(ana.power), 32'h1);
		wait_clk(60);
		for (int i = 0; i < 8; i++) convert(3'(i), 3'(i), i[0], 4'(i));
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			convert(seed[2:0], seed[5:3], seed[6], 4'(seed[15:8] % 13));
		end
		convert(3'h1, 3'h0, 1'b1, 4'd13);
		$display("done: conversions");
		sleep <= 1'b1;
		convert(3'h7, 3'h2, 1'b0, 4'd3);
		wr(OFS_CTRL_C, 8'h00);
		wr(OFS_CTRL_A, 8'h03);
		wait_clk(200);
		rd(OFS_CTRL_A, q);
		check(q, 32'h3);
		check(32'(flag), 32'h0);
		sleep <= 1'b0;
		wr(OFS_CTRL_A, 8'h01);
		wait_clk(20);
		$display("done: sleep");
		wr(OFS_RES_HI, 8'h5a);
		wr(OFS_RES_LO, 8'hc3);
		wr(OFS_CTRL_C, 8'h06);
		wr(OFS_CTRL_A, 8'h03);
		wait_clk(300);
		wr(OFS_CTRL_A, 8'h01);
		t0 = cyc;
		rd(OFS_CTRL_A, q);
		check(q, 32'h1);
		rd(OFS_RES_HI, q);
		check(q, 32'h5a);
		rd(OFS_RES_LO, q);
		check(q, 32'hc3);
		rd(OFS_STATUS, q);
		check(q, 32'h0);
		wait_clk(SETTLE_CLKS + 70);
		check(inr(t_dis - t0, SETTLE_CLKS - 1, SETTLE_CLKS + 2), 32'h1);
		$display("done: abort");
		wr(OFS_CTRL_A, 8'h00);
		check(32'(ana.power), 32'h0);
		wr(OFS_CTRL_A, 8'h01);
		wait_clk(100);
		wr(OFS_CTRL_A, 8'h03);
		wait_clk(100);
		rd(OFS_CTRL_A, q);
		check(q, 32'h3);
		strap <= 1'b0;
		rst_n <= 1'b0;
		wait_clk(12);
		rst_n <= 1'b1;
		@(posedge mclk);
		check({30'h0, ana.power, flag}, 32'h0);
		rd(OFS_CTRL_A, q);
		check(q, 32'h0);
		rd(OFS_CTRL_B, q);
		check(q, 32'(PCFG_RST_DIGITAL));
		rd(OFS_CTRL_C, q);
		check(q, 32'h0);
		$display("done: reset in flight");
		complete_run;
	end
endmodule

`default_nettype wire
